// >>> logic/fdg_pkg.sv
// Shared constants and types for the fieldbus diagnostics / global control handler.
// Assumes a 125 MHz system clock and a 32-bit classic Wishbone register port.
package fdg_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_HZ      = 125_000_000;
	localparam int MS_PER_S    = 1000;
	localparam int CYC_PER_MS  = CLK_HZ / MS_PER_S;

	// ------------------------------------------------------------
	// Message identification
	// ------------------------------------------------------------
	localparam logic [7:0] SVC_DIAG   = 8'h4b;
	localparam logic [7:0] SVC_GC     = 8'h4e;
	localparam logic [7:0] MSG_CLASS  = 8'h65;
	localparam logic [7:0] MSG_INST   = 8'h01;
	localparam logic [7:0] LEN_DIAG   = 8'h08;
	localparam logic [7:0] LEN_GC     = 8'h06;

	// ------------------------------------------------------------
	// Diagnostics request fields
	// ------------------------------------------------------------
	localparam logic [7:0] MODE_BUF   = 8'h00;
	localparam logic [7:0] MODE_CLR   = 8'h01;
	localparam logic [7:0] MODE_FRESH = 8'h02;
	localparam logic [7:0] ADDR_BY_ID = 8'hff;
	localparam logic [7:0] NODE_MAX   = 8'h7e;
	localparam int         NODES      = 127;
	localparam int         DIAG_BYTES = 32;
	localparam logic [5:0] DIAG_FULL  = 6'h20;

	// ------------------------------------------------------------
	// Global control byte
	// ------------------------------------------------------------
	localparam logic [3:0] GC_CLR_REL = 4'h0;
	localparam logic [3:0] GC_CLR     = 4'h2;
	localparam logic [3:0] GC_FRZ     = 4'h4;
	localparam logic [3:0] GC_UNFRZ_A = 4'h8;
	localparam logic [3:0] GC_UNFRZ_B = 4'hc;

	// ------------------------------------------------------------
	// Status codes
	// ------------------------------------------------------------
	localparam logic [7:0] ST_OK      = 8'h00;
	localparam logic [7:0] ST_GC_FAIL = 8'h13;
	localparam logic [7:0] ST_TIMEOUT = 8'h15;
	localparam logic [7:0] ST_BAD     = 8'h16;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] A_CMD      = 8'h00;
	localparam logic [7:0] A_TMO      = 8'h04;
	localparam logic [7:0] A_ARGS     = 8'h08;
	localparam logic [7:0] A_RESP     = 8'h0c;
	localparam logic [7:0] A_PEND0    = 8'h20;
	localparam logic [7:0] A_PEND1    = 8'h24;
	localparam logic [7:0] A_PEND2    = 8'h28;
	localparam logic [7:0] A_PEND3    = 8'h2c;
	localparam logic [7:0] A_IRQ_STAT = 8'h30;
	localparam logic [7:0] A_IRQ_CLR  = 8'h34;
	localparam logic [7:0] A_IRQ_EN   = 8'h38;
	localparam logic [7:0] A_MAP      = 8'h3c;
	localparam logic [7:0] A_DATA     = 8'h40;

	localparam int IRQ_DONE = 0;
	localparam int IRQ_DIAG = 1;
	localparam int IRQ_W    = 2;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] len;
		logic [7:0] inst;
		logic [7:0] cls;
		logic [7:0] svc;
	} fdg_cmd_t;

	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] rsvd;
		logic [7:0] node_id;
		logic [7:0] st_addr;
	} fdg_diag_args_t;

	typedef struct packed {
		logic [15:0] rsvd;
		logic [7:0]  group;
		logic [7:0]  control;
	} fdg_gc_args_t;

	typedef struct packed {
		logic [7:0] rsvd_hi;
		logic [7:0] count;
		logic [7:0] rsvd_lo;
		logic [7:0] status;
	} fdg_resp_t;

	typedef enum logic [1:0] {
		S_IDLE,
		S_CHECK,
		S_DIAG_WAIT,
		S_GC_WAIT
	} fdg_state_t;

endpackage

// >>> logic/fdg_timeout.sv
// Millisecond timeout counter for one outstanding fieldbus request.
// Assumes start_i is a one-cycle pulse on the system clock.
`timescale 1ns/100ps
module fdg_timeout #(
	parameter int CYC_PER_MS = fdg_pkg::CYC_PER_MS
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Control
	input  wire logic        start_i,
	input  wire logic        stop_i,
	input  wire logic [31:0] ms_i,
	// Result
	output logic             expired_o
);

	logic [31:0] pre;
	logic [31:0] remain;
	logic        run;

	// ------------------------------------------------------------
	// Prescaler and countdown
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		expired_o <= 1'b0;
		if (rst_i) begin
			run    <= 1'b0;
			pre    <= '0;
			remain <= '0;
		end else if (start_i) begin
			run    <= 1'b1;
			pre    <= '0;
			remain <= (ms_i == '0) ? 32'h1 : ms_i;
		end else if (stop_i) begin
			run <= 1'b0;
		end else if (run) begin
			if (pre == 32'(CYC_PER_MS - 1)) begin
				pre <= '0;
				if (remain == 32'h1) begin
					run       <= 1'b0;
					expired_o <= 1'b1;
				end else begin
					remain <= remain - 32'h1;
				end
			end else begin
				pre <= pre + 32'h1;
			end
		end
	end

endmodule

// >>> logic/fdg_ctrl.sv
// Diagnostics extraction and global control command handler.
// Assumes a classic Wishbone master and a fieldbus engine on the same clock.
//
// Notes on behaviour
// R1: Target slave chosen by station address or by configured position index.
// R2: Mode 0 returns buffered diagnostics, no new bus request.
// R3: Mode 1 returns buffered diagnostics, then clears the pending flag.
// R4: Mode 2 sends a fresh diagnostic request, returns the reply bytes.
// R5: Diagnostics message is service 0x4B, class 0x65, instance 1, 8 bytes.
// R6: Request holds timeout ms, station address, index, reserved, mode.
// R7: Diagnostics wait ends at timeout with a timeout status.
// R8: Response is status, reserved, byte count, reserved, then the bytes.
// R9: Global control is service 0x4E, class 0x65, instance 1, 6 bytes, multicast.
// R10: Control byte: 0,2,4,8,12 actions plus 16 sync, 32 or 48 unsync.
// R11: Group bit 0 is group 1 up to bit 7 group 8.
// R12: A zero group byte is not supported.
// R13: Global control wait ends at timeout with a timeout status.
// R14: Global control status is 0x00 on success, 0x13 on failure.
// R15: Per-node pending flag vector covers nodes 0 to 126.
// R16: Modes 0 and 2 leave the pending flag unchanged.
//
// The register addresses and the Wishbone slave port were decided locally.
`timescale 1ns/100ps
module fdg_ctrl #(
	parameter int CYC_PER_MS = fdg_pkg::CYC_PER_MS
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Diagnostic bytes from the fieldbus
	input  wire logic        fb_rx_valid_i,
	input  wire logic [6:0]  fb_rx_node_i,
	input  wire logic [7:0]  fb_rx_byte_i,
	input  wire logic        fb_rx_last_i,
	// Global control result
	input  wire logic        fb_gc_done_i,
	input  wire logic        fb_gc_ok_i,
	// Fieldbus request
	output logic             fb_req_o,
	output logic             fb_req_gc_o,
	output logic      [6:0]  fb_node_o,
	output logic      [7:0]  fb_ctl_o,
	output logic      [7:0]  fb_grp_o,
	// Interrupt
	output logic             irq_o
);

	fdg_pkg::fdg_state_t     state;
	fdg_pkg::fdg_cmd_t       cmd;
	fdg_pkg::fdg_resp_t      resp;
	fdg_pkg::fdg_diag_args_t dargs;
	fdg_pkg::fdg_gc_args_t   gargs;
	logic [31:0]             tmo_ms;
	logic [31:0]             args;
	logic [6:0]              cur_node;
	logic                    start_cmd;
	logic                    done_evt;
	logic                    tmr_start;
	logic                    tmo_exp;
	logic [6:0]              node_map [0:fdg_pkg::NODES-1];
	logic [fdg_pkg::NODES-1:0] map_vld;
	logic [fdg_pkg::NODES-1:0] pend;
	logic [7:0]              diag_mem [0:fdg_pkg::NODES*fdg_pkg::DIAG_BYTES-1];
	logic [5:0]              diag_len [0:fdg_pkg::NODES-1];
	logic [5:0]              wr_cnt;
	logic [5:0]              rx_len;
	logic [fdg_pkg::IRQ_W-1:0] irq_stat;
	logic [fdg_pkg::IRQ_W-1:0] irq_en;
	logic [fdg_pkg::IRQ_W-1:0] next_irq_stat;
	logic [31:0]             rd_word;
	logic                    wr_fire;
	logic                    rx_ok;
	logic                    reply_hit;
	logic                    pend_set;
	logic                    by_id;
	logic [6:0]              id_ix;
	logic [6:0]              sel_node;
	logic                    node_ok;
	logic                    diag_ok;
	logic                    gc_ok;
	logic                    ctl_ok;
	logic                    clr_hit;

	assign dargs = fdg_pkg::fdg_diag_args_t'(args);
	assign gargs = fdg_pkg::fdg_gc_args_t'(args);

	// ------------------------------------------------------------
	// Request decode
	// ------------------------------------------------------------
	assign by_id    = (dargs.st_addr == fdg_pkg::ADDR_BY_ID);
	assign id_ix    = (dargs.node_id <= fdg_pkg::NODE_MAX) ? dargs.node_id[6:0] : '0;
	assign sel_node = by_id ? node_map[id_ix] : dargs.st_addr[6:0]; // R1
	assign node_ok  = by_id ? ((dargs.node_id <= fdg_pkg::NODE_MAX) && map_vld[id_ix])
	                        : (dargs.st_addr <= fdg_pkg::NODE_MAX);
	assign diag_ok  = (cmd.svc == fdg_pkg::SVC_DIAG) && (cmd.cls == fdg_pkg::MSG_CLASS)
	                  && (cmd.inst == fdg_pkg::MSG_INST) && (cmd.len == fdg_pkg::LEN_DIAG)
	                  && node_ok && (dargs.mode <= fdg_pkg::MODE_FRESH); // R5 R6
	assign ctl_ok   = (gargs.control[7:6] == 2'h0)
	                  && (gargs.control[3:0] == fdg_pkg::GC_CLR_REL
	                   || gargs.control[3:0] == fdg_pkg::GC_CLR
	                   || gargs.control[3:0] == fdg_pkg::GC_FRZ
	                   || gargs.control[3:0] == fdg_pkg::GC_UNFRZ_A
	                   || gargs.control[3:0] == fdg_pkg::GC_UNFRZ_B); // R10
	assign gc_ok    = (cmd.svc == fdg_pkg::SVC_GC) && (cmd.cls == fdg_pkg::MSG_CLASS)
	                  && (cmd.inst == fdg_pkg::MSG_INST) && (cmd.len == fdg_pkg::LEN_GC)
	                  && ctl_ok && (gargs.group != 8'h00); // R9 R12
	assign clr_hit  = (state == fdg_pkg::S_CHECK) && diag_ok
	                  && (dargs.mode == fdg_pkg::MODE_CLR); // R3 R16

	// ------------------------------------------------------------
	// Fieldbus diagnostic buffer
	// ------------------------------------------------------------
	assign rx_ok     = fb_rx_valid_i && ({1'b0, fb_rx_node_i} <= fdg_pkg::NODE_MAX);
	assign rx_len    = (wr_cnt == fdg_pkg::DIAG_FULL) ? wr_cnt : wr_cnt + 6'h1;
	assign reply_hit = rx_ok && fb_rx_last_i && (fb_rx_node_i == cur_node);
	assign pend_set  = rx_ok && fb_rx_last_i
	                   && !((state == fdg_pkg::S_DIAG_WAIT) && (fb_rx_node_i == cur_node)); // R16

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_cnt <= '0;
			for (int i = 0; i < fdg_pkg::NODES; i++) begin
				diag_len[i] <= '0;
			end
		end else if (rx_ok) begin
			if (wr_cnt != fdg_pkg::DIAG_FULL) begin
				diag_mem[{fb_rx_node_i, wr_cnt[4:0]}] <= fb_rx_byte_i;
			end
			if (fb_rx_last_i) begin
				diag_len[fb_rx_node_i] <= rx_len;
				wr_cnt                 <= '0;
			end else begin
				wr_cnt <= rx_len;
			end
		end
	end

	// ------------------------------------------------------------
	// Pending flag vector
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend <= '0;
		end else begin
			pend <= (pend & ~(clr_hit ? (fdg_pkg::NODES'(1) << sel_node) : '0))
			        | (pend_set ? (fdg_pkg::NODES'(1) << fb_rx_node_i) : '0); // R15 R3
		end
	end

	// ------------------------------------------------------------
	// Timeout
	// ------------------------------------------------------------
	fdg_timeout #(
		.CYC_PER_MS (CYC_PER_MS)
	) u_tmo (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.start_i   (tmr_start),
		.stop_i    (state == fdg_pkg::S_IDLE),
		.ms_i      (tmo_ms),
		.expired_o (tmo_exp)
	);

	// ------------------------------------------------------------
	// Command sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state       <= fdg_pkg::S_IDLE;
			resp        <= '0;
			cur_node    <= '0;
			fb_req_o    <= 1'b0;
			fb_req_gc_o <= 1'b0;
			fb_node_o   <= '0;
			fb_ctl_o    <= '0;
			fb_grp_o    <= '0;
			tmr_start   <= 1'b0;
			done_evt    <= 1'b0;
		end else begin
			fb_req_o  <= 1'b0;
			tmr_start <= 1'b0;
			done_evt  <= 1'b0;
			case (state)
			fdg_pkg::S_IDLE: begin
				if (start_cmd) begin
					state <= fdg_pkg::S_CHECK;
				end
			end
			fdg_pkg::S_CHECK: begin
				state    <= fdg_pkg::S_IDLE;
				done_evt <= 1'b1;
				if (diag_ok) begin
					cur_node <= sel_node;
					if (dargs.mode == fdg_pkg::MODE_FRESH) begin
						fb_req_o    <= 1'b1; // R4
						fb_req_gc_o <= 1'b0;
						fb_node_o   <= sel_node;
						tmr_start   <= 1'b1;
						done_evt    <= 1'b0;
						state       <= fdg_pkg::S_DIAG_WAIT;
					end else begin
						resp <= '{8'h00, 8'(diag_len[sel_node]), 8'h00, fdg_pkg::ST_OK}; // R2 R8
					end
				end else if (gc_ok) begin
					fb_req_o    <= 1'b1; // R9 R11
					fb_req_gc_o <= 1'b1;
					fb_ctl_o    <= gargs.control;
					fb_grp_o    <= gargs.group;
					tmr_start   <= 1'b1;
					done_evt    <= 1'b0;
					state       <= fdg_pkg::S_GC_WAIT;
				end else begin
					resp <= '{8'h00, 8'h00, 8'h00, fdg_pkg::ST_BAD};
				end
			end
			fdg_pkg::S_DIAG_WAIT: begin
				if (reply_hit) begin
					resp     <= '{8'h00, 8'(rx_len), 8'h00, fdg_pkg::ST_OK}; // R4 R8
					state    <= fdg_pkg::S_IDLE;
					done_evt <= 1'b1;
				end else if (tmo_exp) begin
					resp     <= '{8'h00, 8'h00, 8'h00, fdg_pkg::ST_TIMEOUT}; // R7
					state    <= fdg_pkg::S_IDLE;
					done_evt <= 1'b1;
				end
			end
			fdg_pkg::S_GC_WAIT: begin
				if (fb_gc_done_i) begin
					resp  <= '{8'h00, 8'h00, 8'h00,
					           fb_gc_ok_i ? fdg_pkg::ST_OK : fdg_pkg::ST_GC_FAIL}; // R14
					state    <= fdg_pkg::S_IDLE;
					done_evt <= 1'b1;
				end else if (tmo_exp) begin
					resp     <= '{8'h00, 8'h00, 8'h00, fdg_pkg::ST_TIMEOUT}; // R13
					state    <= fdg_pkg::S_IDLE;
					done_evt <= 1'b1;
				end
			end
			default: begin
				state <= fdg_pkg::S_IDLE;
			end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Wishbone registers
	// ------------------------------------------------------------
	assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
	                                      input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

	always_comb begin
		rd_word = '0;
		case (wb_adr_i)
		fdg_pkg::A_CMD:      rd_word = {31'h0, state != fdg_pkg::S_IDLE};
		fdg_pkg::A_TMO:      rd_word = tmo_ms;
		fdg_pkg::A_ARGS:     rd_word = args;
		fdg_pkg::A_RESP:     rd_word = resp;
		fdg_pkg::A_PEND0:    rd_word = pend[31:0];
		fdg_pkg::A_PEND1:    rd_word = pend[63:32];
		fdg_pkg::A_PEND2:    rd_word = pend[95:64];
		fdg_pkg::A_PEND3:    rd_word = {1'b0, pend[126:96]};
		fdg_pkg::A_IRQ_STAT: rd_word = 32'(irq_stat);
		fdg_pkg::A_IRQ_EN:   rd_word = 32'(irq_en);
		default: begin
			if (wb_adr_i[7:5] == fdg_pkg::A_DATA[7:5]) begin
				for (int b = 0; b < 4; b++) begin
					rd_word[b*8 +: 8] = diag_mem[{cur_node, wb_adr_i[4:2], 2'(b)}];
				end
			end
		end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o  <= 1'b0;
			wb_dat_o  <= '0;
			cmd       <= '0;
			tmo_ms    <= '0;
			args      <= '0;
			irq_en    <= '0;
			map_vld   <= '0;
			start_cmd <= 1'b0;
		end else begin
			wb_ack_o  <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			start_cmd <= 1'b0;
			if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
				wb_dat_o <= rd_word;
			end
			if (wr_fire) begin
				case (wb_adr_i)
				fdg_pkg::A_CMD: begin
					if (state == fdg_pkg::S_IDLE) begin
						cmd       <= merge(cmd, wb_dat_i, wb_sel_i);
						start_cmd <= 1'b1;
					end
				end
				fdg_pkg::A_TMO:    tmo_ms <= merge(tmo_ms, wb_dat_i, wb_sel_i);
				fdg_pkg::A_ARGS:   args   <= merge(args, wb_dat_i, wb_sel_i);
				fdg_pkg::A_IRQ_EN: irq_en <= wb_dat_i[fdg_pkg::IRQ_W-1:0];
				fdg_pkg::A_MAP: begin
					if ({1'b0, wb_dat_i[14:8]} <= fdg_pkg::NODE_MAX) begin
						node_map[wb_dat_i[14:8]] <= wb_dat_i[6:0]; // R1
						map_vld[wb_dat_i[14:8]]  <= 1'b1;
					end
				end
				default: begin
				end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Interrupt
	// ------------------------------------------------------------
	always_comb begin
		next_irq_stat = irq_stat;
		if (wr_fire && wb_adr_i == fdg_pkg::A_IRQ_CLR) begin
			next_irq_stat = irq_stat & ~wb_dat_i[fdg_pkg::IRQ_W-1:0];
		end
		next_irq_stat[fdg_pkg::IRQ_DONE] = next_irq_stat[fdg_pkg::IRQ_DONE] | done_evt;
		next_irq_stat[fdg_pkg::IRQ_DIAG] = next_irq_stat[fdg_pkg::IRQ_DIAG] | pend_set;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat <= '0;
			irq_o    <= 1'b0;
		end else begin
			irq_stat <= next_irq_stat;
			irq_o    <= |(next_irq_stat & irq_en);
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_chk_diag(logic [7:0] m);
		(state == fdg_pkg::S_CHECK) && diag_ok && (dargs.mode == m);
	endsequence

	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_buf_read: assert property (s_chk_diag(fdg_pkg::MODE_BUF) |=> // R2
		!fb_req_o && done_evt && resp.status == fdg_pkg::ST_OK)
		else $error("buffered read issued a bus request");
	a_mode1_clear: assert property ((s_chk_diag(fdg_pkg::MODE_CLR) // R3
		and !(pend_set && fb_rx_node_i == sel_node)) |=> !pend[cur_node])
		else $error("pending flag not cleared after mode 1");
	a_fresh_req: assert property (s_chk_diag(fdg_pkg::MODE_FRESH) |=> // R4
		fb_req_o && !fb_req_gc_o && fb_node_o == cur_node ##1 !fb_req_o)
		else $error("fresh diagnostic request not issued");
	a_keep_pending: assert property (((state == fdg_pkg::S_CHECK) && diag_ok // R16
		&& dargs.mode != fdg_pkg::MODE_CLR && pend[sel_node]) |=> pend[cur_node])
		else $error("pending flag lost in mode 0 or 2");
	a_diag_timeout: assert property ((state == fdg_pkg::S_DIAG_WAIT && tmo_exp // R7
		&& !reply_hit) |=> state == fdg_pkg::S_IDLE && resp.status == fdg_pkg::ST_TIMEOUT)
		else $error("diagnostics timeout not reported");
	a_gc_timeout: assert property ((state == fdg_pkg::S_GC_WAIT && tmo_exp // R13
		&& !fb_gc_done_i) |=> done_evt && resp.status == fdg_pkg::ST_TIMEOUT)
		else $error("global control timeout not reported");
	a_gc_status: assert property ((state == fdg_pkg::S_GC_WAIT && fb_gc_done_i) |=> // R14
		resp.status == ($past(fb_gc_ok_i) ? fdg_pkg::ST_OK : fdg_pkg::ST_GC_FAIL))
		else $error("global control status wrong");
	a_gc_group: assert property ((fb_req_o && fb_req_gc_o) |-> // R11 R12 R10
		fb_grp_o != 8'h00 && fb_ctl_o[7:6] == 2'h0)
		else $error("global control sent with bad group or control");
	a_bad_request: assert property (((state == fdg_pkg::S_CHECK) && !diag_ok && !gc_ok) // R5 R9
		|=> resp.status == fdg_pkg::ST_BAD && !fb_req_o)
		else $error("malformed request not refused");
	a_pend_set: assert property (pend_set |=> pend[$past(fb_rx_node_i)]) // R15
		else $error("pending flag not set on new diagnostics");

endmodule

// >>> verification/fdg_fb_model.sv
// Behavioural fieldbus engine at the far side of the handler.
// Assumes the handler clock; the bench steers reply length, silence and result.
`timescale 1ns/100ps
module fdg_fb_model (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Bench control
	input  wire logic       inject_i,
	input  wire logic [6:0] inj_node_i,
	input  wire logic [5:0] len_i,
	input  wire logic       silent_i,
	input  wire logic       ok_i,
	// Handler request
	input  wire logic       req_i,
	input  wire logic       req_gc_i,
	input  wire logic [6:0] node_i,
	// Replies
	output logic            rx_valid_o,
	output logic      [6:0] rx_node_o,
	output logic      [7:0] rx_byte_o,
	output logic            rx_last_o,
	output logic            gc_done_o,
	output logic            gc_ok_o
);
	logic [5:0] cnt;
	logic [6:0] node;
	// Idle lines toggle so stale values never look valid
	always_ff @(posedge clk_i) begin
		rx_valid_o <= 1'b0;
		rx_last_o  <= 1'b0;
		gc_done_o  <= 1'b0;
		gc_ok_o    <= ~gc_ok_o;
		rx_byte_o  <= ~rx_byte_o;
		rx_node_o  <= ~rx_node_o;
		if (rst_i) begin
			cnt       <= 6'h00;
			gc_ok_o   <= 1'b0;
			rx_byte_o <= 8'h00;
			rx_node_o <= 7'h00;
		end else if (cnt != 6'h00) begin
			rx_valid_o <= 1'b1;
			rx_node_o  <= node;
			rx_byte_o  <= 8'(node) + 8'(len_i - cnt);
			rx_last_o  <= (cnt == 6'h01);
			cnt        <= cnt - 6'h01;
		end else if (inject_i) begin
			node <= inj_node_i;
			cnt  <= len_i;
		end else if (req_i && !silent_i) begin
			if (req_gc_i) begin
				gc_done_o <= 1'b1;
				gc_ok_o   <= ok_i;
			end else begin
				node <= node_i;
				cnt  <= len_i;
			end
		end
	end
endmodule

// >>> verification/tb_fieldbus_diag_global_control.sv
// Self-checking bench for the diagnostics and global control handler.
// Assumes the fieldbus model beside it and a shortened millisecond count.
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb_fieldbus_diag_global_control;
	logic        clk_i, rst_i, cyc, stb, we, ack, rxv, rxl, gcd, gco;
	logic        req, reqgc, irq, inj, silent, ok;
	logic [7:0]  adr, rxb, ctl, grp;
	logic [6:0]  rxn, node, injn;
	logic [5:0]  len;
	logic [31:0] wdat, rdat;
	int          miscompares, total_checks, req_cnt;

	fdg_ctrl #(.CYC_PER_MS(4)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .fb_rx_valid_i(rxv), .fb_rx_node_i(rxn),
		.fb_rx_byte_i(rxb), .fb_rx_last_i(rxl), .fb_gc_done_i(gcd), .fb_gc_ok_i(gco),
		.fb_req_o(req), .fb_req_gc_o(reqgc), .fb_node_o(node), .fb_ctl_o(ctl),
		.fb_grp_o(grp), .irq_o(irq));
	fdg_fb_model fbm (.clk_i(clk_i), .rst_i(rst_i), .inject_i(inj), .inj_node_i(injn),
		.len_i(len), .silent_i(silent), .ok_i(ok), .req_i(req), .req_gc_i(reqgc),
		.node_i(node), .rx_valid_o(rxv), .rx_node_o(rxn), .rx_byte_o(rxb),
		.rx_last_o(rxl), .gc_done_o(gcd), .gc_ok_o(gco));

	always @(posedge clk_i) if (req === 1'b1) req_cnt++;

	task automatic summarize();
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// One classic Wishbone cycle, held until ack is sampled
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n = 0;
		@(posedge clk_i);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
		do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 20);
		q = rdat;
		if (n >= 20) begin miscompares++; summarize(); end
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0, q);
	endtask

	// Issue one command and wait for the done status bit
	task automatic cmd(input logic [7:0] svc, l, input logic [31:0] args,
		output logic [31:0] r);
		logic [31:0] q;
		int n = 0;
		wr(fdg_pkg::A_IRQ_CLR, 32'h1);
		wr(fdg_pkg::A_ARGS, args);
		wr(fdg_pkg::A_CMD, fdg_pkg::fdg_cmd_t'{l, 8'h01, 8'h65, svc});
		do begin rd(fdg_pkg::A_IRQ_STAT, q); n++; end while (q[0] !== 1'b1 && n < 100);
		if (n >= 100) begin miscompares++; summarize(); end
		rd(fdg_pkg::A_RESP, r);
	endtask
	function automatic logic [31:0] dg(input logic [7:0] m, i, s);
		return fdg_pkg::fdg_diag_args_t'{m, 8'h00, i, s};
	endfunction

	task automatic t_buffered();
		logic [31:0] q, r;
		int c;
		wr(fdg_pkg::A_IRQ_EN, 32'h2);
		len <= 6'h03; injn <= 7'h05; inj <= 1'b1;
		@(posedge clk_i);
		inj <= 1'b0;
		repeat (8) @(posedge clk_i);
		`CHK(irq, 1'b1)
		rd(fdg_pkg::A_PEND0, q);
		`CHK(q[5], 1'b1)
		wr(fdg_pkg::A_IRQ_CLR, 32'h2);
		c = req_cnt;
		cmd(8'h4b, 8'h08, dg(8'h00, 8'h00, 8'h05), r);
		`CHK(r, 32'h00030000)
		`CHK(req_cnt, c)
		`CHK(irq, 1'b0)
		rd(fdg_pkg::A_DATA, q);
		`CHK(q[23:0], 24'h070605)
		rd(fdg_pkg::A_PEND0, q);
		`CHK(q[5], 1'b1)
		cmd(8'h4b, 8'h08, dg(8'h01, 8'h00, 8'h05), r);
		`CHK(r, 32'h00030000)
		rd(fdg_pkg::A_PEND0, q);
		`CHK(q[5], 1'b0)
	endtask

	task automatic t_fresh();
		logic [31:0] q, r;
		int c = req_cnt;
		wr(fdg_pkg::A_MAP, 32'h00000109);
		len <= 6'h04;
		cmd(8'h4b, 8'h08, dg(8'h02, 8'h01, 8'hff), r);
		`CHK(r, 32'h00040000)
		`CHK(node, 7'h09)
		`CHK(req_cnt, c + 1)
		rd(fdg_pkg::A_DATA, q);
		`CHK(q, 32'h0c0b0a09)
		rd(fdg_pkg::A_PEND0, q);
		`CHK(q[9], 1'b0)
	endtask

	task automatic t_gc();
		logic [7:0] cs [8] = '{8'h00, 8'h02, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h28, 8'h30};
		logic [7:0] g;
		logic [31:0] r;
		int c;
		for (int i = 0; i < 8; i++) begin
			g = (8'h80 >> i) | 8'h01;
			ok <= (i != 3);
			cmd(8'h4e, 8'h06, fdg_pkg::fdg_gc_args_t'{16'h0, g, cs[i]}, r);
			`CHK(r[7:0], (i != 3) ? 8'h00 : 8'h13)
			`CHK({reqgc, ctl, grp}, {1'b1, cs[i], g})
		end
		silent <= 1'b1;
		cmd(8'h4e, 8'h06, 32'h00000104, r);
		`CHK(r[7:0], fdg_pkg::ST_TIMEOUT)
		cmd(8'h4b, 8'h08, dg(8'h02, 8'h00, 8'h07), r);
		`CHK(r[23:0], {8'h00, 8'h00, fdg_pkg::ST_TIMEOUT})
		silent <= 1'b0;
		c = req_cnt;
		cmd(8'h4e, 8'h06, 32'h00000004, r);
		`CHK(r[7:0], fdg_pkg::ST_BAD)
		cmd(8'h4b, 8'h07, dg(8'h00, 8'h00, 8'h05), r);
		`CHK(r[7:0], fdg_pkg::ST_BAD)
		cmd(8'h4b, 8'h08, dg(8'h03, 8'h00, 8'h05), r);
		`CHK(r[7:0], fdg_pkg::ST_BAD)
		cmd(8'h4e, 8'h06, 32'h00000146, r);
		`CHK(r[7:0], fdg_pkg::ST_BAD)
		cmd(8'h4b, 8'h08, dg(8'h00, 8'h02, 8'hff), r);
		`CHK(r[7:0], fdg_pkg::ST_BAD)
		cmd(8'h4b, 8'h08, dg(8'h00, 8'h00, 8'h7f), r);
		`CHK(r[7:0], fdg_pkg::ST_BAD)
		`CHK(req_cnt, c)
		rd(8'h80, r);
		`CHK(r, 32'h0)
	endtask

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	initial begin
		{rst_i, cyc, stb, we, adr, wdat, inj, injn, len, silent, ok} = '0;
		rst_i = 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		wr(fdg_pkg::A_TMO, 32'h2);
		t_buffered();
		t_fresh();
		t_gc();
		summarize();
	end
endmodule
